// ### inc/phy_mac_pkg.sv
package phy_mac_pkg;

  // Clock arithmetic in kHz so every ratio stays an exact integer
  localparam int REF_CLK_KHZ = 250000;
  localparam int LINK_CLK_10_KHZ = 2500;
  localparam int LINK_CLK_100_KHZ = 25000;
  localparam int LINK_CLK_1000_KHZ = 125000;
  localparam int GTX_CLK_KHZ = 125000;

  // Terminal counts of the half-period dividers (half period minus one)
  localparam logic [5:0] HALF_10 = 6'(REF_CLK_KHZ / (2 * LINK_CLK_10_KHZ) - 1);
  localparam logic [5:0] HALF_100 = 6'(REF_CLK_KHZ / (2 * LINK_CLK_100_KHZ) - 1);
  localparam logic [5:0] HALF_1000 = 6'(REF_CLK_KHZ / (2 * LINK_CLK_1000_KHZ) - 1);
  localparam logic [5:0] GTX_HALF = 6'(REF_CLK_KHZ / (2 * GTX_CLK_KHZ) - 1);

  // Crossing ring: four entries addressed by a 2-bit Gray pointer
  localparam int RING_DEPTH = 4;
  localparam logic [1:0] PTR_RESET = 2'h0;

  // Ring word: data[9:2], enable or valid [1], error [0]
  localparam int WORD_W = 10;
  localparam int WORD_EN = 1;
  localparam int WORD_ER = 0;

  // Synced MII transmit pins: error [5], enable [4], nibble [3:0]
  localparam int MII_ER = 5;
  localparam int MII_EN = 4;

  typedef enum logic [1:0] {
    IF_MII = 2'b00,
    IF_GMII = 2'b01,
    IF_RGMII = 2'b11
  } if_mode_type;

  typedef enum logic [1:0] {
    SPEED_10 = 2'b00,
    SPEED_100 = 2'b01,
    SPEED_1000 = 2'b11
  } speed_type;

  typedef enum logic [1:0] {
    CODE_IDLE = 2'b00,
    CODE_DATA = 2'b01,
    CODE_INVALID = 2'b11,
    CODE_HALT = 2'b10
  } tx_code_type;

  function automatic logic [1:0] gray_next(input logic [1:0] g);
    case (g)
      2'b00: gray_next = 2'b01;
      2'b01: gray_next = 2'b11;
      2'b11: gray_next = 2'b10;
      default: gray_next = 2'b00;
    endcase
  endfunction : gray_next

  function automatic logic [5:0] half_count(input speed_type s);
    case (s)
      SPEED_1000: half_count = HALF_1000;
      SPEED_100: half_count = HALF_100;
      default: half_count = HALF_10;
    endcase
  endfunction : half_count

endpackage : phy_mac_pkg

// ### inc/phy_mac_link.sv
`timescale 1ns/1ps
interface phy_mac_link;
  logic gtx_clk;
  logic tx_clk;
  logic rx_clk;
  logic [7:0] txd;
  logic tx_ctl;
  logic tx_er;
  logic [7:0] rxd;
  logic rx_ctl;
  logic rx_er;
  logic col;
  logic crs;

  modport phy (
    input gtx_clk,
    input txd,
    input tx_ctl,
    input tx_er,
    output tx_clk,
    output rx_clk,
    output rxd,
    output rx_ctl,
    output rx_er,
    output col,
    output crs
  );

  modport mac (
    output gtx_clk,
    output txd,
    output tx_ctl,
    output tx_er,
    input tx_clk,
    input rx_clk,
    input rxd,
    input rx_ctl,
    input rx_er,
    input col,
    input crs
  );
endinterface : phy_mac_link

// ### hw/phy_link_end.sv
`timescale 1ns/1ps
// Summary of operation
// [RL1] Transmit nibble sampled on mode's transmit clock
// [RL2] GMII transmit error yields invalid code-groups
// [RL3] MII error: invalid, then halt until released
// [RL4] MAC supplies continuous 125MHz transmit clock
// [RL5] Receive clock 2.5, 25 or 125MHz
// [RL6] Receive data on receive clock; byte GMII
// [RL7] MAC raises enable while data presented
// [RL8] RGMII control carries enable and error, DDR
// [RL9] Receive valid high while data present
// [RL10] RGMII receive control combines valid and error
// [RL11] Receive error high on error; RGMII unused
// [RL12] Half duplex: collision on simultaneous activity; held low in RGMII here
// [RL13] Full duplex: collision held low
// [RL14] Half duplex: carrier sense on any activity; held low in RGMII here
// [RL15] Full duplex 10/100: carrier on receive only; held low in RGMII here
// [RL16] MII transmit clock 2.5 or 25MHz
// [RL17] RGMII falling sample is value xor error
module phy_link_end (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire phy_mac_pkg::if_mode_type if_mode,
  input wire phy_mac_pkg::speed_type speed,
  input wire logic full_duplex,
  phy_mac_link.phy link,
  output logic [7:0] line_tx_data,
  output phy_mac_pkg::tx_code_type line_tx_code,
  output logic line_tx_strobe,
  input wire logic [7:0] line_rx_data,
  input wire logic line_rx_dv,
  input wire logic line_rx_err,
  input wire logic line_rx_carrier,
  output logic line_rx_taken
);
  import phy_mac_pkg::*;

  logic [7:0] cap_rise;
  logic cap_ctl_rise;
  logic cap_er_rise;
  logic [WORD_W-1:0] ring [RING_DEPTH];
  logic [1:0] wr_gray;
  logic [1:0] wr_sync1;
  logic [1:0] wr_sync2;
  logic [1:0] wr_sync3;
  logic [1:0] rd_gray;
  logic [WORD_W-1:0] ring_word;
  logic word_ready;
  logic [5:0] div_cnt;
  logic clk_int;
  logic link_edge;
  logic rise_edge;
  logic fall_edge;
  logic [5:0] mii_sync1;
  logic [5:0] mii_sync2;
  logic [5:0] mii_sync3;
  logic [5:0] mii_hold;
  logic err_run;
  logic tx_active;
  logic tx_take;
  logic [7:0] next_tx_data;
  tx_code_type next_tx_code;
  logic [3:0] rx_hi;
  logic rx_valid_error_combined;

  // Transmit capture on the MAC clock; it is free running, so no frame gating
  always_ff @(posedge link.gtx_clk or negedge rst_b) begin // RL4
    if (!rst_b) begin
      cap_rise <= 8'h00;
      cap_ctl_rise <= 1'b0;
      cap_er_rise <= 1'b0;
    end else begin
      cap_rise <= link.txd; // RL1
      cap_ctl_rise <= link.tx_ctl;
      cap_er_rise <= link.tx_er;
    end
  end

  always_ff @(negedge link.gtx_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_gray <= PTR_RESET;
    end else if (if_mode != IF_MII) begin
      wr_gray <= gray_next(wr_gray);
    end
  end

  // Falling edge completes the word; ring drains on the reference clock at the fill rate, one word per stable pointer
  always_ff @(negedge link.gtx_clk) begin
    if (if_mode == IF_RGMII) begin
      ring[wr_gray] <= {link.txd[3:0], cap_rise[3:0], cap_ctl_rise,
                        cap_ctl_rise ^ link.tx_ctl}; // RL8 RL17
    end else begin
      ring[wr_gray] <= {cap_rise, cap_ctl_rise, cap_er_rise}; // RL1
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_sync1 <= PTR_RESET;
      wr_sync2 <= PTR_RESET;
      wr_sync3 <= PTR_RESET;
    end else if (ce) begin
      wr_sync1 <= wr_gray;
      wr_sync2 <= wr_sync1;
      wr_sync3 <= wr_sync2;
    end
  end

  assign word_ready = (if_mode != IF_MII) && (wr_sync2 == wr_sync3) && (rd_gray != wr_sync3);
  assign ring_word = ring[rd_gray];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_gray <= PTR_RESET;
    end else if (ce && word_ready) begin
      rd_gray <= gray_next(rd_gray);
    end
  end

  // Shared divider for both clocks this end drives
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 6'h00;
      clk_int <= 1'b0;
    end else if (ce) begin
      if (div_cnt >= half_count(speed)) begin
        div_cnt <= 6'h00;
        clk_int <= ~clk_int;
      end else begin
        div_cnt <= div_cnt + 6'h01;
      end
    end
  end

  assign link_edge = ce && (div_cnt >= half_count(speed));
  assign rise_edge = link_edge && !clk_int;
  assign fall_edge = link_edge && clk_int;

  // Pins lag the internal phase by half a cycle, so data leads each pin edge
  always_ff @(negedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      link.rx_clk <= 1'b0;
      link.tx_clk <= 1'b0;
    end else if (ce) begin
      link.rx_clk <= clk_int; // RL5
      link.tx_clk <= (if_mode == IF_MII) ? clk_int : 1'b0; // RL16
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mii_sync1 <= 6'h00;
      mii_sync2 <= 6'h00;
      mii_sync3 <= 6'h00;
      mii_hold <= 6'h00;
    end else if (ce) begin
      mii_sync1 <= {link.tx_er, link.tx_ctl, link.txd[3:0]};
      mii_sync2 <= mii_sync1;
      mii_sync3 <= mii_sync2;
      if (mii_sync2 == mii_sync3) begin
        mii_hold <= mii_sync3;
      end
    end
  end

  always_comb begin
    tx_take = 1'b0;
    next_tx_data = 8'h00;
    next_tx_code = CODE_IDLE;
    if (if_mode == IF_MII) begin
      if (fall_edge) begin // RL1
        tx_take = 1'b1;
        next_tx_data = {4'h0, mii_hold[3:0]};
        if (mii_hold[MII_ER]) begin
          next_tx_code = err_run ? CODE_HALT : CODE_INVALID; // RL3
        end else if (mii_hold[MII_EN]) begin
          next_tx_code = CODE_DATA; // RL7
        end
      end
    end else if (ce && word_ready) begin
      tx_take = 1'b1;
      next_tx_data = ring_word[9:2];
      if (ring_word[WORD_EN] && ring_word[WORD_ER]) begin
        next_tx_code = CODE_INVALID; // RL2
      end else if (ring_word[WORD_EN]) begin
        next_tx_code = CODE_DATA; // RL7
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_tx_strobe <= 1'b0;
      line_tx_data <= 8'h00;
      line_tx_code <= CODE_IDLE;
      err_run <= 1'b0;
      tx_active <= 1'b0;
    end else if (ce) begin
      line_tx_strobe <= tx_take;
      if (tx_take) begin
        line_tx_data <= next_tx_data;
        line_tx_code <= next_tx_code;
        err_run <= (if_mode == IF_MII) && mii_hold[MII_ER]; // RL3
        tx_active <= (next_tx_code != CODE_IDLE);
      end
    end
  end

  // Receive pins change only at internal phase edges
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      link.rxd <= 8'h00;
      link.rx_ctl <= 1'b0;
      link.rx_er <= 1'b0;
      rx_hi <= 4'h0;
      rx_valid_error_combined <= 1'b0;
      line_rx_taken <= 1'b0;
    end else if (ce) begin
      line_rx_taken <= rise_edge;
      if (rise_edge && (if_mode == IF_RGMII)) begin
        link.rxd <= {4'h0, line_rx_data[3:0]}; // RL6
        link.rx_ctl <= line_rx_dv; // RL10
        link.rx_er <= 1'b0; // RL11
        rx_hi <= (speed == SPEED_1000) ? line_rx_data[7:4] : line_rx_data[3:0];
        rx_valid_error_combined <= line_rx_dv ^ line_rx_err; // RL17
      end else if (rise_edge) begin
        link.rxd <= (if_mode == IF_GMII) ? line_rx_data : {4'h0, line_rx_data[3:0]}; // RL6
        link.rx_ctl <= line_rx_dv; // RL9
        link.rx_er <= line_rx_err; // RL11
      end else if (fall_edge && (if_mode == IF_RGMII)) begin
        link.rxd <= {4'h0, rx_hi}; // RL6
        link.rx_ctl <= rx_valid_error_combined; // RL10
      end
    end
  end

  // Collision and carrier follow line state, not any interface clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      link.col <= 1'b0;
      link.crs <= 1'b0;
    end else if (ce) begin
      link.col <= (if_mode != IF_RGMII) && !full_duplex && tx_active
                  && line_rx_carrier; // RL12 RL13
      if (if_mode == IF_RGMII) begin
        link.crs <= 1'b0;
      end else if (!full_duplex) begin
        link.crs <= tx_active || line_rx_carrier; // RL14
      end else begin
        link.crs <= (speed != SPEED_1000) && line_rx_carrier; // RL15
      end
    end
  end

endmodule : phy_link_end

// ### hw/mac_link_end.sv
`timescale 1ns/1ps
module mac_link_end (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire phy_mac_pkg::if_mode_type if_mode,
  input wire phy_mac_pkg::speed_type speed,
  phy_mac_link.mac link,
  input wire logic [7:0] mac_tx_data,
  input wire logic mac_tx_valid,
  input wire logic mac_tx_err,
  output logic mac_tx_taken,
  output logic mac_rx_strobe,
  output logic [7:0] mac_rx_data,
  output logic mac_rx_dv,
  output logic mac_rx_err,
  output logic mac_crs,
  output logic mac_col
);
  import phy_mac_pkg::*;

  logic [5:0] gtx_cnt;
  logic gtx_int;
  logic gtx_rise;
  logic gtx_fall;
  logic [2:0] tclk_sync;
  logic tclk_level;
  logic mii_fall;
  logic take;
  logic [3:0] tx_hi;
  logic tx_fall_ctl;
  logic [7:0] rx_cap;
  logic rx_cap_ctl;
  logic rx_cap_er;
  logic [WORD_W-1:0] ring [RING_DEPTH];
  logic [1:0] wr_gray;
  logic [1:0] wr_sync1;
  logic [1:0] wr_sync2;
  logic [1:0] wr_sync3;
  logic [1:0] rd_gray;
  logic word_ready;
  logic [WORD_W-1:0] ring_word;
  logic [1:0] cc_sync1;
  logic [1:0] cc_sync2;
  logic [1:0] cc_sync3;

  // Gigabit transmit clock by division, driven out half a cycle late
  always_ff @(posedge ref_clk or negedge rst_b) begin // RL4
    if (!rst_b) begin
      gtx_cnt <= 6'h00;
      gtx_int <= 1'b0;
    end else if (ce) begin
      if (gtx_cnt >= GTX_HALF) begin
        gtx_cnt <= 6'h00;
        gtx_int <= ~gtx_int;
      end else begin
        gtx_cnt <= gtx_cnt + 6'h01;
      end
    end
  end

  assign gtx_rise = ce && (gtx_cnt >= GTX_HALF) && !gtx_int;
  assign gtx_fall = ce && (gtx_cnt >= GTX_HALF) && gtx_int;

  always_ff @(negedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      link.gtx_clk <= 1'b0;
    end else if (ce) begin
      link.gtx_clk <= gtx_int;
    end
  end

  // PHY transmit clock seen as a pin; its fall launches the next nibble
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tclk_sync <= 3'h0;
      tclk_level <= 1'b0;
    end else if (ce) begin
      tclk_sync <= {tclk_sync[1:0], link.tx_clk};
      if (tclk_sync[1] == tclk_sync[2]) begin
        tclk_level <= tclk_sync[2];
      end
    end
  end

  assign mii_fall = ce && (tclk_sync[1] == tclk_sync[2]) && !tclk_sync[2] && tclk_level;
  assign take = (if_mode == IF_MII) ? mii_fall : gtx_rise;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      link.txd <= 8'h00;
      link.tx_ctl <= 1'b0;
      link.tx_er <= 1'b0;
      tx_hi <= 4'h0;
      tx_fall_ctl <= 1'b0;
      mac_tx_taken <= 1'b0;
    end else if (ce) begin
      mac_tx_taken <= take;
      if (take && (if_mode == IF_RGMII)) begin
        link.txd <= {4'h0, mac_tx_data[3:0]}; // RL1
        link.tx_ctl <= mac_tx_valid; // RL8
        link.tx_er <= 1'b0;
        tx_hi <= mac_tx_data[7:4];
        tx_fall_ctl <= mac_tx_valid ^ mac_tx_err; // RL17
      end else if (take) begin
        link.txd <= (if_mode == IF_GMII) ? mac_tx_data : {4'h0, mac_tx_data[3:0]}; // RL1
        link.tx_ctl <= mac_tx_valid; // RL7
        link.tx_er <= mac_tx_err; // RL2
      end else if (gtx_fall && (if_mode == IF_RGMII)) begin
        link.txd <= {4'h0, tx_hi};
        link.tx_ctl <= tx_fall_ctl; // RL8
      end
    end
  end

  // Receive capture on the PHY clock, which runs continuously
  always_ff @(posedge link.rx_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_cap <= 8'h00;
      rx_cap_ctl <= 1'b0;
      rx_cap_er <= 1'b0;
    end else begin
      rx_cap <= link.rxd;
      rx_cap_ctl <= link.rx_ctl;
      rx_cap_er <= link.rx_er;
    end
  end

  always_ff @(negedge link.rx_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_gray <= PTR_RESET;
    end else begin
      wr_gray <= gray_next(wr_gray);
    end
  end

  always_ff @(negedge link.rx_clk) begin
    if (if_mode == IF_RGMII) begin
      ring[wr_gray] <= {(speed == SPEED_1000) ? link.rxd[3:0] : 4'h0, rx_cap[3:0],
                        rx_cap_ctl, rx_cap_ctl ^ link.rx_ctl}; // RL10 RL17
    end else if (if_mode == IF_GMII) begin
      ring[wr_gray] <= {rx_cap, rx_cap_ctl, rx_cap_er}; // RL6 RL9
    end else begin
      ring[wr_gray] <= {4'h0, rx_cap[3:0], rx_cap_ctl, rx_cap_er}; // RL6 RL9
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_sync1 <= PTR_RESET;
      wr_sync2 <= PTR_RESET;
      wr_sync3 <= PTR_RESET;
      rd_gray <= PTR_RESET;
    end else if (ce) begin
      wr_sync1 <= wr_gray;
      wr_sync2 <= wr_sync1;
      wr_sync3 <= wr_sync2;
      if (word_ready) begin
        rd_gray <= gray_next(rd_gray);
      end
    end
  end

  assign word_ready = (wr_sync2 == wr_sync3) && (rd_gray != wr_sync3);
  assign ring_word = ring[rd_gray];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mac_rx_strobe <= 1'b0;
      mac_rx_data <= 8'h00;
      mac_rx_dv <= 1'b0;
      mac_rx_err <= 1'b0;
    end else if (ce) begin
      mac_rx_strobe <= word_ready;
      if (word_ready) begin
        mac_rx_data <= ring_word[9:2];
        mac_rx_dv <= ring_word[WORD_EN];
        mac_rx_err <= ring_word[WORD_ER];
      end
    end
  end

  // Collision and carrier arrive unrelated to any clock here
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cc_sync1 <= 2'h0;
      cc_sync2 <= 2'h0;
      cc_sync3 <= 2'h0;
      mac_col <= 1'b0;
      mac_crs <= 1'b0;
    end else if (ce) begin
      cc_sync1 <= {link.col, link.crs};
      cc_sync2 <= cc_sync1;
      cc_sync3 <= cc_sync2;
      if (cc_sync2[1] == cc_sync3[1]) begin
        mac_col <= cc_sync3[1]; // RL12
      end
      if (cc_sync2[0] == cc_sync3[0]) begin
        mac_crs <= cc_sync3[0]; // RL14
      end
    end
  end

endmodule : mac_link_end

// ### verif/phy_mac_checker.sv
`timescale 1ns/1ps
module phy_mac_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire phy_mac_pkg::if_mode_type if_mode,
  input wire phy_mac_pkg::speed_type speed,
  input wire logic full_duplex,
  input wire logic gtx_clk,
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic tx_er,
  input wire logic rx_er,
  input wire logic col,
  input wire logic crs
);
  import phy_mac_pkg::*;
  logic prev_rx;
  logic [6:0] run;
  logic [1:0] edges;
  logic [6:0] exp_half;
  // Half period less one, in reference cycles
  assign exp_half = (speed == SPEED_1000) ? 7'h0 : (speed == SPEED_100) ? 7'h4 : 7'h31;
  // First two edges after reset are skipped: the first half period starts inside reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_rx <= 1'b0;
      run <= 7'h0;
      edges <= 2'h0;
    end else begin
      prev_rx <= rx_clk;
      run <= (rx_clk != prev_rx) ? 7'h0 : run + 7'h1;
      if (rx_clk != prev_rx && edges != 2'h2) begin
        edges <= edges + 2'h1;
      end
    end
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence gtx_cycle;
    $fell(gtx_clk) ##1 $rose(gtx_clk);
  endsequence
  AST_GTX_RUN: assert property ($rose(gtx_clk) |=> gtx_cycle)
    else $error("transmit clock not continuous");
  AST_RX_HALF: assert property (rx_clk != prev_rx && edges == 2'h2 |-> run == exp_half)
    else $error("receive clock half period wrong");
  AST_TXCLK_OFF: assert property (if_mode != IF_MII |-> !tx_clk)
    else $error("mii transmit clock outside mii");
  AST_COL_FULL: assert property (full_duplex |-> !col)
    else $error("collision in full duplex");
  AST_COL_RGMII: assert property (if_mode == IF_RGMII |-> !col [*4])
    else $error("collision in rgmii");
  AST_COL_CRS: assert property ($rose(col) |-> crs)
    else $error("collision without carrier sense");
  AST_CRS_RGMII: assert property (if_mode == IF_RGMII |-> !crs)
    else $error("carrier sense in rgmii");
  AST_CRS_FULL_GIG: assert property (full_duplex && speed == SPEED_1000 |-> !crs)
    else $error("carrier sense in gigabit full duplex");
  AST_RXER_RGMII: assert property (if_mode == IF_RGMII |-> !rx_er)
    else $error("receive error pin used in rgmii");
  AST_TXER_RGMII: assert property (if_mode == IF_RGMII |-> !tx_er)
    else $error("transmit error pin used in rgmii");
endmodule : phy_mac_checker

// ### verif/test_phy_mac_side_port.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module test_phy_mac_side_port;
  import phy_mac_pkg::*;
  logic ref_clk, rst_b, ce, full_duplex, hold_tx, prev_e, rx_full;
  if_mode_type if_mode;
  speed_type speed;
  tx_code_type line_tx_code;
  logic [7:0] mac_tx_data, line_tx_data, line_rx_data, mac_rx_data;
  logic mac_tx_valid, mac_tx_err, mac_tx_taken, line_tx_strobe, line_rx_dv, line_rx_err;
  logic line_rx_carrier, line_rx_taken, mac_rx_strobe, mac_rx_dv, mac_rx_err, mac_crs, mac_col;
  logic [31:0] seed;
  logic [9:0] tx_q[$];
  logic [9:0] rx_q[$];
  logic [9:0] tx_x, rx_x, tx_got, rx_got;
  int miscompares, n_compared;

  phy_mac_link link();
  phy_link_end phy_link_end_i (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .if_mode(if_mode),
    .speed(speed), .full_duplex(full_duplex), .link(link), .line_tx_data(line_tx_data),
    .line_tx_code(line_tx_code), .line_tx_strobe(line_tx_strobe), .line_rx_data(line_rx_data),
    .line_rx_dv(line_rx_dv), .line_rx_err(line_rx_err), .line_rx_carrier(line_rx_carrier),
    .line_rx_taken(line_rx_taken));
  mac_link_end mac_link_end_i (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .if_mode(if_mode),
    .speed(speed), .link(link), .mac_tx_data(mac_tx_data), .mac_tx_valid(mac_tx_valid),
    .mac_tx_err(mac_tx_err), .mac_tx_taken(mac_tx_taken), .mac_rx_strobe(mac_rx_strobe),
    .mac_rx_data(mac_rx_data), .mac_rx_dv(mac_rx_dv), .mac_rx_err(mac_rx_err),
    .mac_crs(mac_crs), .mac_col(mac_col));
  phy_mac_checker phy_mac_checker_i (.ref_clk(ref_clk), .rst_b(rst_b), .if_mode(if_mode),
    .speed(speed), .full_duplex(full_duplex), .gtx_clk(link.gtx_clk), .tx_clk(link.tx_clk),
    .rx_clk(link.rx_clk), .tx_er(link.tx_er), .rx_er(link.rx_er), .col(link.col),
    .crs(link.crs));

  always #2 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // A word may change only after its taken pulse, never before
  task automatic wait_pulse(input logic sel);
    int k;
    for (k = 0; k < 400; k++) begin
      @(negedge ref_clk);
      if ((sel ? line_rx_taken : mac_tx_taken) === 1'b1) break;
    end
    if (k == 400) begin
      miscompares++;
      wrap_up();
    end
  endtask : wait_pulse

  task automatic send_tx(input int n);
    logic [31:0] r;
    logic [9:0] x;
    for (int i = 0; i <= n; i++) begin
      wait_pulse(1'b0);
      x = {2'b00, (if_mode == IF_MII) ? {4'h0, mac_tx_data[3:0]} : mac_tx_data};
      if (if_mode == IF_MII) begin
        x[9:8] = mac_tx_valid ? CODE_DATA : CODE_IDLE;
        if (mac_tx_err) begin
          x[9:8] = prev_e ? CODE_HALT : CODE_INVALID;
        end
      end else begin
        x[9:8] = mac_tx_valid ? (mac_tx_err ? CODE_INVALID : CODE_DATA) : CODE_IDLE;
      end
      prev_e = mac_tx_err;
      if (x[9:8] != CODE_DATA) x[7:0] = 8'h0;
      if (i > 0 && x[9:8] != CODE_IDLE) tx_q.push_back(x);
      r = xs();
      mac_tx_data = r[7:0];
      mac_tx_err = (i < n) & r[10] & r[11];
      mac_tx_valid = (i < n) & (r[8] | r[9] | (mac_tx_err & (if_mode == IF_MII)));
    end
  endtask : send_tx

  task automatic send_rx(input int n);
    logic [31:0] r;
    logic [9:0] w;
    for (int i = 0; i <= n; i++) begin
      wait_pulse(1'b1);
      if (i > 0 && line_rx_dv) begin
        w = {line_rx_dv, line_rx_err, line_rx_data};
        if (!rx_full) begin
          w[7:4] = 4'h0;
        end
        rx_q.push_back(w);
      end
      r = xs();
      line_rx_data = r[7:0];
      line_rx_dv = (i < n) & (r[8] | r[9]);
      line_rx_err = line_rx_dv & r[10] & r[11];
    end
  endtask : send_rx

  always @(negedge ref_clk) begin
    if (line_tx_strobe === 1'b1 && !hold_tx && line_tx_code !== CODE_IDLE) begin
      tx_x = (tx_q.size() > 0) ? tx_q.pop_front() : 10'h0;
      tx_got = {line_tx_code, (line_tx_code == CODE_DATA) ? line_tx_data : 8'h0};
      `CHK("line_tx", tx_x, tx_got)
    end
    if (mac_rx_strobe === 1'b1 && mac_rx_dv !== 1'b0) begin
      rx_x = (rx_q.size() > 0) ? rx_q.pop_front() : 10'h0;
      rx_got = {mac_rx_dv, mac_rx_err, mac_rx_data};
      if (!rx_full) begin
        rx_got[7:4] = 4'h0;
      end
      `CHK("mac_rx", rx_x, rx_got)
    end
  end

  task automatic chk_cs(input logic tx_on, input logic car);
    logic rg;
    logic want;
    rg = (if_mode == IF_RGMII);
    want = rg ? 1'b0 : (!full_duplex ? (tx_on | car) : (speed != SPEED_1000 && car));
    line_rx_carrier = car;
    mac_tx_valid = tx_on;
    repeat (300) @(negedge ref_clk);
    `CHK("mac_crs", want, mac_crs)
    `CHK("mac_col", !rg & !full_duplex & tx_on & car, mac_col)
  endtask : chk_cs

  task automatic run(input if_mode_type m, input speed_type s, input logic fd);
    int k;
    rst_b = 1'b0;
    if_mode = m;
    speed = s;
    full_duplex = fd;
    {mac_tx_valid, mac_tx_err, line_rx_dv, line_rx_err, line_rx_carrier} = 5'h0;
    {prev_e, hold_tx} = 2'b00;
    rx_full = (m != IF_MII) && (s == SPEED_1000);
    tx_q.delete();
    rx_q.delete();
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    fork
      send_tx(12);
      send_rx(12);
    join
    for (k = 0; k < 600 && (tx_q.size() + rx_q.size()) > 0; k++) @(negedge ref_clk);
    `CHK("words left", 0, tx_q.size() + rx_q.size())
    hold_tx = 1'b1;
    mac_tx_err = 1'b0;
    chk_cs(1'b1, 1'b1);
    chk_cs(1'b1, 1'b0);
    chk_cs(1'b0, 1'b1);
    chk_cs(1'b0, 1'b0);
    $display("test done mode %0d speed %0d full %0d", m, s, fd);
  endtask : run

  initial begin
    {ref_clk, rst_b, ce, full_duplex, hold_tx, prev_e, rx_full} = 7'b0010000;
    if_mode = IF_MII;
    speed = SPEED_10;
    {mac_tx_data, line_rx_data} = 16'h0;
    {mac_tx_valid, mac_tx_err, line_rx_dv, line_rx_err, line_rx_carrier} = 5'h0;
    seed = 32'h35;
    miscompares = 0;
    n_compared = 0;
    run(IF_MII, SPEED_10, 1'b0);
    run(IF_MII, SPEED_100, 1'b1);
    run(IF_GMII, SPEED_1000, 1'b0);
    run(IF_GMII, SPEED_1000, 1'b1);
    run(IF_RGMII, SPEED_1000, 1'b1);
    run(IF_RGMII, SPEED_100, 1'b0);
    wrap_up();
  end
endmodule : test_phy_mac_side_port
